// ===== rtl/prd_cfg.svh
`ifndef PRD_CFG_SVH
`define PRD_CFG_SVH

`define PRD_OFS_CHK_BASE 8'h60
`define PRD_OFS_CHK_MASK 8'h68
`define PRD_OFS_STL_BASE 8'h70
`define PRD_OFS_STL_MASK 8'h78

`define PRD_ADDR_HI      39
`define PRD_ADDR_LO      19
`define PRD_RSV_HI       63
`define PRD_RSV_LO       40
`define PRD_ENABLE_BIT   11
`define PRD_LOCK_BIT     10

`define PRD_FIELD_RST    21'h000000
`define PRD_FLAG_RST     1'b0

`endif

// ===== rtl/prd_pkg.sv
package prd_pkg;
  typedef logic [20:0] prd_field_t;
  typedef logic [39:0] prd_addr_t;
  typedef logic [63:0] prd_qword_t;
  typedef enum logic {PRD_WIN_CHECK, PRD_WIN_STOLEN} prd_win_t;
endpackage

// ===== rtl/prd_window.sv
`timescale 1ns/1ps
`default_nettype none
`include "prd_cfg.svh"
// one protected window: base and mask pair with enable and lock
module prd_window (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               base_wr,
  input  wire logic               mask_wr,
  input  wire prd_pkg::prd_qword_t wdata,
  input  wire prd_pkg::prd_addr_t  addr,
  output var  prd_pkg::prd_field_t base_q,
  output var  prd_pkg::prd_field_t mask_q,
  output var  logic               enable_q,
  output var  logic               lock_q,
  output var  logic               hit
);
  prd_pkg::prd_field_t base_ff;
  prd_pkg::prd_field_t mask_ff;
  logic                enable_ff;
  logic                lock_ff;
  wire                 base_take;
  wire                 mask_take;
  prd_pkg::prd_field_t addr_field;

  // a set lock freezes both registers, lock included, until reset
  assign base_take  = base_wr & ~lock_ff;
  assign mask_take  = mask_wr & ~lock_ff;
  assign addr_field = addr[`PRD_ADDR_HI:`PRD_ADDR_LO];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_ff   <= `PRD_FIELD_RST;
      mask_ff   <= `PRD_FIELD_RST;
      enable_ff <= `PRD_FLAG_RST;
      lock_ff   <= `PRD_FLAG_RST;
    end else begin
      if (base_take) begin
        base_ff <= wdata[`PRD_ADDR_HI:`PRD_ADDR_LO];
      end
      if (mask_take) begin
        mask_ff   <= wdata[`PRD_ADDR_HI:`PRD_ADDR_LO];
        enable_ff <= wdata[`PRD_ENABLE_BIT];
        lock_ff   <= wdata[`PRD_LOCK_BIT];
      end
    end
  end

  assign base_q   = base_ff;
  assign mask_q   = mask_ff;
  assign enable_q = enable_ff;
  assign lock_q   = lock_ff;
  // masked compare; no alignment check, misaligned bases simply match oddly
  assign hit = enable_ff & ((addr_field & mask_ff) == (base_ff & mask_ff));
endmodule
`default_nettype wire

// ===== rtl/prd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "prd_cfg.svh"
module prd_decoder (
  input  wire logic                MCLK,
  input  wire logic                RESETN,
  input  wire logic [7:0]          CFG_ADDR,
  input  wire logic                CFG_WR,
  input  wire logic                CFG_RD,
  input  wire prd_pkg::prd_qword_t CFG_WDATA,
  output var  prd_pkg::prd_qword_t CFG_RDATA,
  output var  logic                CFG_RVALID,
  input  wire logic                CORE_REQ,
  input  wire prd_pkg::prd_addr_t  CORE_ADDR,
  output var  logic                CORE_DONE,
  output var  logic                CORE_ABORT,
  input  wire logic                CHIP_REQ,
  input  wire prd_pkg::prd_addr_t  CHIP_ADDR,
  output var  logic                CHIP_DONE,
  output var  logic                CHIP_ABORT,
  output var  logic                MACHINE_CHECK
);
  localparam int NWIN = 2;

  wire                 base_wr [NWIN];
  wire                 mask_wr [NWIN];
  prd_pkg::prd_addr_t  win_addr [NWIN];
  prd_pkg::prd_field_t base_q [NWIN];
  prd_pkg::prd_field_t mask_q [NWIN];
  logic                enable_q [NWIN];
  logic                lock_q [NWIN];
  logic                hit [NWIN];

  prd_pkg::prd_qword_t rdata_ff;
  logic                rvalid_ff;
  logic                core_done_ff;
  logic                core_abort_ff;
  logic                chip_done_ff;
  logic                chip_abort_ff;
  logic                mcheck_ff;
  prd_pkg::prd_qword_t nxt_rdata;

  // decode: qword registers, so only exact offsets are mapped
  assign base_wr[prd_pkg::PRD_WIN_CHECK]  = CFG_WR & (CFG_ADDR == `PRD_OFS_CHK_BASE);
  assign mask_wr[prd_pkg::PRD_WIN_CHECK]  = CFG_WR & (CFG_ADDR == `PRD_OFS_CHK_MASK);
  assign base_wr[prd_pkg::PRD_WIN_STOLEN] = CFG_WR & (CFG_ADDR == `PRD_OFS_STL_BASE);
  assign mask_wr[prd_pkg::PRD_WIN_STOLEN] = CFG_WR & (CFG_ADDR == `PRD_OFS_STL_MASK);
  // the check segment guards chipset traffic, the stolen range guards core traffic
  assign win_addr[prd_pkg::PRD_WIN_CHECK]  = CHIP_ADDR;
  assign win_addr[prd_pkg::PRD_WIN_STOLEN] = CORE_ADDR;

  genvar w;
  generate
    for (w = 0; w < NWIN; w++) begin : g_win
      prd_window u_win (
        .clk      (MCLK),
        .rst_n    (RESETN),
        .base_wr  (base_wr[w]),
        .mask_wr  (mask_wr[w]),
        .wdata    (CFG_WDATA),
        .addr     (win_addr[w]),
        .base_q   (base_q[w]),
        .mask_q   (mask_q[w]),
        .enable_q (enable_q[w]),
        .lock_q   (lock_q[w]),
        .hit      (hit[w])
      );
    end
  endgenerate

  wire prd_pkg::prd_qword_t chk_base_rd;
  wire prd_pkg::prd_qword_t chk_mask_rd;
  wire prd_pkg::prd_qword_t stl_base_rd;
  wire prd_pkg::prd_qword_t stl_mask_rd;

  // reserved bits read zero
  assign chk_base_rd = {24'h000000, base_q[prd_pkg::PRD_WIN_CHECK], 19'h00000};
  assign chk_mask_rd = {24'h000000, mask_q[prd_pkg::PRD_WIN_CHECK], 7'h00,
                        enable_q[prd_pkg::PRD_WIN_CHECK], lock_q[prd_pkg::PRD_WIN_CHECK],
                        10'h000};
  assign stl_base_rd = {24'h000000, base_q[prd_pkg::PRD_WIN_STOLEN], 19'h00000};
  assign stl_mask_rd = {24'h000000, mask_q[prd_pkg::PRD_WIN_STOLEN], 7'h00,
                        enable_q[prd_pkg::PRD_WIN_STOLEN], lock_q[prd_pkg::PRD_WIN_STOLEN],
                        10'h000};

  // unmapped offsets read zero
  assign nxt_rdata = (CFG_ADDR == `PRD_OFS_CHK_BASE) ? chk_base_rd :
                     (CFG_ADDR == `PRD_OFS_CHK_MASK) ? chk_mask_rd :
                     (CFG_ADDR == `PRD_OFS_STL_BASE) ? stl_base_rd :
                     (CFG_ADDR == `PRD_OFS_STL_MASK) ? stl_mask_rd :
                     64'h0000000000000000;

  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      rdata_ff  <= 64'h0000000000000000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= CFG_RD;
      if (CFG_RD) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // verdict one cycle after the request; address is only looked at with its request
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      core_done_ff  <= 1'b0;
      core_abort_ff <= 1'b0;
      chip_done_ff  <= 1'b0;
      chip_abort_ff <= 1'b0;
      mcheck_ff     <= 1'b0;
    end else begin
      core_done_ff  <= CORE_REQ;
      core_abort_ff <= CORE_REQ & hit[prd_pkg::PRD_WIN_STOLEN];
      chip_done_ff  <= CHIP_REQ;
      chip_abort_ff <= CHIP_REQ & hit[prd_pkg::PRD_WIN_CHECK];
      mcheck_ff     <= CHIP_REQ & hit[prd_pkg::PRD_WIN_CHECK];
    end
  end

  assign CFG_RDATA     = rdata_ff;
  assign CFG_RVALID    = rvalid_ff;
  assign CORE_DONE     = core_done_ff;
  assign CORE_ABORT    = core_abort_ff;
  assign CHIP_DONE     = chip_done_ff;
  assign CHIP_ABORT    = chip_abort_ff;
  assign MACHINE_CHECK = mcheck_ff;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  wire prd_pkg::prd_field_t chip_f = CHIP_ADDR[`PRD_ADDR_HI:`PRD_ADDR_LO];
  wire prd_pkg::prd_field_t core_f = CORE_ADDR[`PRD_ADDR_HI:`PRD_ADDR_LO];
  wire chip_in = (((chip_f ^ base_q[0]) & mask_q[0]) == 21'h000000);
  wire core_in = (((core_f ^ base_q[1]) & mask_q[1]) == 21'h000000);
  wire core_guard = enable_q[1] && core_in;
  wire prd_pkg::prd_field_t wr_field = CFG_WDATA[`PRD_ADDR_HI:`PRD_ADDR_LO];
  wire wr_enable = CFG_WDATA[`PRD_ENABLE_BIT];

  sequence chk_locked_write;
    lock_q[0] && (base_wr[0] || mask_wr[0]);
  endsequence
  sequence stl_locked_write;
    lock_q[1] && (base_wr[1] || mask_wr[1]);
  endsequence

  chk_abort_a: assert property (CHIP_REQ && enable_q[0] && chip_in |=>
    CHIP_ABORT && MACHINE_CHECK && CHIP_DONE) else $error("check segment hit not aborted");
  chk_quiet_a: assert property ((CHIP_REQ && !enable_q[0]) || !CHIP_REQ |=>
    !CHIP_ABORT && !MACHINE_CHECK) else $error("abort without enabled check segment");
  chk_lock_a: assert property (chk_locked_write |=>
    $stable(base_q[0]) && $stable(mask_q[0]) && lock_q[0] && $stable(enable_q[0]))
    else $error("locked check segment changed");
  stl_abort_a: assert property (CORE_REQ |=>
    CORE_DONE && (CORE_ABORT == $past(core_guard)))
    else $error("stolen range verdict wrong");
  stl_lock_a: assert property (stl_locked_write ##1 1'b1 [*2] |->
    lock_q[1] && stl_mask_rd == $past(stl_mask_rd, 2)) else $error("locked stolen range changed");
  range_miss_a: assert property (CORE_REQ && enable_q[1] && !core_in |=> !CORE_ABORT)
    else $error("abort outside stolen range");
  rsv_zero_a: assert property (CFG_RVALID |->
    CFG_RDATA[`PRD_RSV_HI:`PRD_RSV_LO] == 24'h000000
    && CFG_RDATA[9:0] == 10'h000) else $error("reserved bits not zero");
  reset_clear_a: assert property (disable iff (1'b0) !RESETN |=>
    !lock_q[0] && !lock_q[1] && !enable_q[0] && !enable_q[1] && base_q[1] == 21'h000000)
    else $error("reset did not clear window");
  mask_match_a: assert property (CHIP_REQ && enable_q[0] && !chip_in |=> !CHIP_ABORT)
    else $error("chipset abort on masked mismatch");

  // pulses last one cycle; a stuck verdict would abort the next access too
  chip_done_a: assert property (
    CHIP_REQ |=> CHIP_DONE)
    else $error("chipset access not completed");
  chip_idle_a: assert property (
    !CHIP_REQ |=> !CHIP_DONE && !CHIP_ABORT)
    else $error("chipset verdict without request");
  mcheck_pair_a: assert property (
    MACHINE_CHECK == CHIP_ABORT)
    else $error("machine check differs from chipset abort");
  core_idle_a: assert property (
    !CORE_REQ |=> !CORE_DONE && !CORE_ABORT)
    else $error("core verdict without request");
  abort_done_a: assert property (
    CORE_ABORT |-> CORE_DONE)
    else $error("core abort without completion");
  stl_quiet_a: assert property (
    CORE_REQ && !enable_q[1] |=> !CORE_ABORT)
    else $error("abort from disabled stolen range");
  rvalid_next_a: assert property (
    CFG_RD |=> CFG_RVALID)
    else $error("read answer missing");
  rvalid_idle_a: assert property (
    !CFG_RD |=> !CFG_RVALID)
    else $error("read answer without request");
  rdata_hold_a: assert property (
    !CFG_RD |=> $stable(CFG_RDATA))
    else $error("read data moved without a read");
  chk_sticky_a: assert property (
    lock_q[0] |=> lock_q[0])
    else $error("check segment lock dropped");
  stl_sticky_a: assert property (
    lock_q[1] |=> lock_q[1])
    else $error("stolen range lock dropped");
  base_land_a: assert property (
    base_wr[1] && !lock_q[1] |=> base_q[1] == $past(wr_field))
    else $error("stolen range base write lost");
  mask_land_a: assert property (
    mask_wr[0] && !lock_q[0] |=> mask_q[0] == $past(wr_field) && enable_q[0] == $past(wr_enable))
    else $error("check segment mask write lost");
endmodule
`default_nettype wire

// ===== dv/prd_requester.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for a core or chipset agent, one access at a time
module prd_requester (
  input  wire logic               clk,
  output var  logic               req,
  output var  prd_pkg::prd_addr_t addr,
  input  wire logic               done,
  input  wire logic               abort
);
  initial begin
    req = 1'b0;
    addr = 40'h00_0000_0000;
  end
  task automatic issue(input prd_pkg::prd_addr_t a, output logic d, output logic ab);
    @(negedge clk);
    req = 1'b1;
    addr = a;
    @(negedge clk);
    d = done;
    ab = abort;
    req = 1'b0;
    // address is not held once the request is gone
    addr = ~a;
  endtask
endmodule
`default_nettype wire

// ===== dv/test_prd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "prd_cfg.svh"
module test_prd_decoder;
  localparam logic [7:0] cb = `PRD_OFS_CHK_BASE;
  localparam logic [7:0] cm = `PRD_OFS_CHK_MASK;
  localparam logic [7:0] sb = `PRD_OFS_STL_BASE;
  localparam logic [7:0] sm = `PRD_OFS_STL_MASK;
  logic                mclk = 1'b0;
  logic                resetn = 1'b0;
  logic [7:0]          cfg_addr = 8'h00;
  logic                cfg_wr = 1'b0;
  logic                cfg_rd = 1'b0;
  prd_pkg::prd_qword_t cfg_wdata = 64'h0;
  prd_pkg::prd_qword_t cfg_rdata;
  prd_pkg::prd_addr_t  core_addr, chip_addr;
  logic                cfg_rvalid, core_req, core_done, core_abort;
  logic                chip_req, chip_done, chip_abort, mcheck;
  int                  num_errors = 0;
  int                  samples_checked = 0;
  always #4 mclk = ~mclk;
  prd_decoder dut (.MCLK(mclk), .RESETN(resetn), .CFG_ADDR(cfg_addr), .CFG_WR(cfg_wr),
    .CFG_RD(cfg_rd), .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid),
    .CORE_REQ(core_req), .CORE_ADDR(core_addr), .CORE_DONE(core_done),
    .CORE_ABORT(core_abort), .CHIP_REQ(chip_req), .CHIP_ADDR(chip_addr),
    .CHIP_DONE(chip_done), .CHIP_ABORT(chip_abort), .MACHINE_CHECK(mcheck));
  prd_requester core_ag (.clk(mclk), .req(core_req), .addr(core_addr), .done(core_done),
    .abort(core_abort));
  prd_requester chip_ag (.clk(mclk), .req(chip_req), .addr(chip_addr), .done(chip_done),
    .abort(chip_abort));
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_q(input prd_pkg::prd_qword_t got, input prd_pkg::prd_qword_t exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_acc(input logic d, input logic ab, input logic mc, input logic e,
                         input logic em);
    samples_checked++;
    if (d !== 1'b1 || ab !== e || mc !== em) begin
      num_errors++;
      $display("FAIL %0t access done %b abort %b check %b", $time, d, ab, mc);
    end
  endtask
  task automatic wr(input logic [7:0] a, input prd_pkg::prd_qword_t v);
    @(negedge mclk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = v;
    @(negedge mclk);
    cfg_wr = 1'b0;
    cfg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, input prd_pkg::prd_qword_t e);
    int n;
    @(negedge mclk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge mclk);
    cfg_rd = 1'b0;
    // rvalid is due now; a late answer counts as an error, and none within 4 cycles ends the run
    for (n = 0; n < 4 && cfg_rvalid !== 1'b1; n++) @(negedge mclk);
    if (n != 0) begin
      num_errors++;
      $display("FAIL %0t read answer late or missing", $time);
      if (n == 4) wrap_up();
    end
    chk_q(cfg_rdata, e);
  endtask
  task automatic acc(input bit chip, input prd_pkg::prd_addr_t a, input logic e);
    logic d, ab;
    if (chip) chip_ag.issue(a, d, ab);
    else core_ag.issue(a, d, ab);
    chk_acc(d, ab, mcheck, e, chip ? e : 1'b0);
  endtask
  task automatic do_reset;
    @(negedge mclk);
    resetn = 1'b0;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
  endtask
  initial begin
    do_reset();
    rd(cb, 64'h0);
    rd(cm, 64'h0);
    rd(sb, 64'h0);
    rd(sm, 64'h0);
    rd(8'h80, 64'h0);
    wr(sb, 64'hffff_ffff_ffff_ffff);
    rd(sb, 64'h0000_00ff_fff8_0000);
    wr(cb, 64'h0000_0000_1000_0000);
    wr(cm, 64'h0000_00ff_ffe0_0000);
    acc(1, 40'h00_1000_0000, 1'b0);
    wr(cm, 64'h0000_00ff_ffe0_0800);
    acc(1, 40'h00_101f_ffff, 1'b1);
    acc(1, 40'h00_1020_0000, 1'b0);
    acc(0, 40'h00_1000_0000, 1'b0);
    wr(sb, 64'h0000_0000_8000_0000);
    wr(sm, 64'h0000_00ff_fff8_0800);
    acc(0, 40'h00_8007_ffff, 1'b1);
    acc(0, 40'h00_8008_0000, 1'b0);
    acc(0, 40'h00_7fff_ffff, 1'b0);
    acc(1, 40'h00_8000_0000, 1'b0);
    wr(cm, 64'h0000_00ff_ffe0_0c00);
    wr(cb, 64'h0);
    wr(cm, 64'h0);
    rd(cb, 64'h0000_0000_1000_0000);
    rd(cm, 64'h0000_00ff_ffe0_0c00);
    acc(1, 40'h00_1000_0000, 1'b1);
    wr(sm, 64'h0000_00ff_fff8_0c00);
    wr(sb, 64'h0);
    rd(sm, 64'h0000_00ff_fff8_0c00);
    rd(sb, 64'h0000_0000_8000_0000);
    do_reset();
    rd(cm, 64'h0);
    rd(sm, 64'h0);
    wr(cb, 64'h0000_0000_2000_0000);
    rd(cb, 64'h0000_0000_2000_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
